// >>> src/cpac_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "cpac_defines.vh"

module cpac_ctrl #(
	parameter CAL_CYCLES = `CPAC_CAL_US * `CPAC_CLK_MHZ,
	parameter CW         = 20
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        hw_powerdown_pin_n,
	input  wire        wr_stb,
	input  wire [4:0]  wr_addr,
	input  wire [15:0] wr_data,
	input  wire        serial_frame_sync,
	input  wire        conversion_clock_pin,
	output reg         master_clk_out_en,
	output reg         bitclk_out1_en,
	output reg         bitclk_out2_en,
	output reg         bitclk_out3_en,
	output reg         convclk_out1_en,
	output reg         convclk_out2_en,
	output reg         convclk_out3_en,
	output reg         clkgen_one_en,
	output reg         clkgen_two_en,
	output reg         clkgen_three_en,
	output reg         headphone_drv_en,
	output reg         dac_to_dac_mix_en,
	output reg         analog_mix_en,
	output reg         adc_left_pwr,
	output reg         adc_right_pwr,
	output reg         dac_one_pwr,
	output reg         dac_two_pwr,
	output reg         analog_pwr,
	output reg         adc_left_run,
	output reg         adc_right_run,
	output reg         dac_one_run,
	output reg         dac_two_run,
	output reg         cal_busy,
	output reg         cal_valid,
	output reg         hw_pd_active
);

// =============================================================
// Calibration states
localparam ST_IDLE = 2'b00;
localparam ST_CAL  = 2'b01;
localparam ST_DONE = 2'b10;

// Cut to the counter width on purpose; CAL_CYCLES must fit in CW bits
localparam [31:0]   CAL_LAST_FULL = CAL_CYCLES - 1;
localparam [CW-1:0] CAL_LAST      = CAL_LAST_FULL[CW-1:0];

// =============================================================
// Input synchronisers
// Only the second flop of each chain is read, so metastability stays contained
reg [1:0] pd_sync_reg;
reg [1:0] fs_sync_reg;
reg [1:0] cv_sync_reg;
reg       fs_prev_reg;
reg       cv_prev_reg;

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		pd_sync_reg <= 2'h0;
		fs_sync_reg <= 2'h0;
		cv_sync_reg <= 2'h0;
		fs_prev_reg <= 1'b0;
		cv_prev_reg <= 1'b0;
	end else begin
		pd_sync_reg <= {pd_sync_reg[0], ~hw_powerdown_pin_n};
		fs_sync_reg <= {fs_sync_reg[0], serial_frame_sync};
		cv_sync_reg <= {cv_sync_reg[0], conversion_clock_pin};
		fs_prev_reg <= fs_sync_reg[1];
		cv_prev_reg <= cv_sync_reg[1];
	end
end

wire hw_pd   = pd_sync_reg[1];
wire fs_rise = fs_sync_reg[1] & ~fs_prev_reg;
wire cv_rise = cv_sync_reg[1] & ~cv_prev_reg;

// =============================================================
// Control words for addresses 27 and 28
reg [15:0] pwr_a_reg;
reg [15:0] pwr_b_reg;
wire wr_a = wr_stb & (wr_addr == `CPAC_ADDR_PWR_A);
wire wr_b = wr_stb & (wr_addr == `CPAC_ADDR_PWR_B);

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		pwr_a_reg <= `CPAC_RST_A;
		pwr_b_reg <= `CPAC_RST_B;
	end else if (hw_pd) begin
		// Pin power-down returns the settings to their reset state
		pwr_a_reg <= `CPAC_RST_A;
		pwr_b_reg <= `CPAC_RST_B;
	end else begin
		if (wr_a)
			pwr_a_reg <= wr_data;
		if (wr_b)
			pwr_b_reg <= wr_data;
	end
end

// Software power-down means every converter path is off or converter_pd is set
function sw_down;
	input [15:0] a;
	input [15:0] b;
	begin
		sw_down = b[`CPAC_B_PDC] | ~(a[`CPAC_B_ADL] | a[`CPAC_B_ADR] |
			a[`CPAC_B_DA1] | a[`CPAC_B_DA2]);
	end
endfunction

wire sw_down_now = sw_down(pwr_a_reg, pwr_b_reg);
reg  sw_down_prev_reg;

// =============================================================
// Calibration sequencer
reg [1:0]    cal_st_reg;
reg [CW-1:0] cal_cnt_reg;
reg          cal_ok_reg;
reg [1:0]    cal_st_next;
reg [CW-1:0] cal_cnt_next;
reg          cal_ok_next;
wire         wake_edge = sw_down_prev_reg & ~sw_down_now;

always @* begin
	cal_st_next  = cal_st_reg;
	cal_cnt_next = cal_cnt_reg;
	cal_ok_next  = cal_ok_reg;
	case (cal_st_reg)
	ST_IDLE: begin
		// No valid data after reset or pin power-down: calibrate unprompted
		cal_st_next  = ST_CAL;
		cal_cnt_next = {CW{1'b0}};
	end
	ST_CAL: begin
		if (cal_cnt_reg == CAL_LAST) begin
			cal_st_next = ST_DONE;
			cal_ok_next = 1'b1;
		end else begin
			cal_cnt_next = cal_cnt_reg + 1'b1;
		end
	end
	ST_DONE: begin
		// Wake from software power-down keeps old data unless asked
		if (wake_edge && pwr_b_reg[`CPAC_B_ACW]) begin
			cal_st_next  = ST_CAL;
			cal_cnt_next = {CW{1'b0}};
		end
	end
	default: begin
		cal_st_next  = ST_IDLE;
		cal_cnt_next = {CW{1'b0}};
	end
	endcase
end

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		cal_st_reg       <= ST_IDLE;
		cal_cnt_reg      <= {CW{1'b0}};
		cal_ok_reg       <= 1'b0;
		sw_down_prev_reg <= 1'b1;
	end else if (hw_pd) begin
		// Pin power-down throws the data away and holds off a new run
		cal_st_reg       <= ST_IDLE;
		cal_cnt_reg      <= {CW{1'b0}};
		cal_ok_reg       <= 1'b0;
		sw_down_prev_reg <= 1'b1;
	end else begin
		cal_st_reg       <= cal_st_next;
		cal_cnt_reg      <= cal_cnt_next;
		cal_ok_reg       <= cal_ok_next;
		sw_down_prev_reg <= sw_down_now;
	end
end

wire running_cal = (cal_st_reg != ST_DONE);

// =============================================================
// Channel start gate: sixth frame sync then a conversion clock edge
reg [2:0] fs_cnt_reg [0:3];
reg [3:0] armed_reg;
reg [3:0] run_reg;
wire [3:0] ch_pwr;

// A converter path is up only while its enable is set and converter_pd is clear
function chan_on;
	input en;
	input pd;
	begin
		chan_on = en & ~pd;
	end
endfunction

assign ch_pwr[0] = chan_on(pwr_a_reg[`CPAC_B_ADL], pwr_b_reg[`CPAC_B_PDC]);
assign ch_pwr[1] = chan_on(pwr_a_reg[`CPAC_B_ADR], pwr_b_reg[`CPAC_B_PDC]);
assign ch_pwr[2] = chan_on(pwr_a_reg[`CPAC_B_DA1], pwr_b_reg[`CPAC_B_PDC]);
assign ch_pwr[3] = chan_on(pwr_a_reg[`CPAC_B_DA2], pwr_b_reg[`CPAC_B_PDC]);

// Rewriting an enable that is already set does not restart the count
integer i;
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		for (i = 0; i < 4; i = i + 1)
			fs_cnt_reg[i] <= 3'h0;
		armed_reg <= 4'h0;
		run_reg   <= 4'h0;
	end else begin
		for (i = 0; i < 4; i = i + 1) begin
			if (!ch_pwr[i] || hw_pd) begin
				fs_cnt_reg[i] <= 3'h0;
				armed_reg[i]  <= 1'b0;
				run_reg[i]    <= 1'b0;
			end else if (!run_reg[i]) begin
				if (armed_reg[i] && cv_rise)
					run_reg[i] <= 1'b1;
				else if (!armed_reg[i] && fs_rise) begin
					if (fs_cnt_reg[i] == `CPAC_FS_WAIT - 3'h1)
						armed_reg[i] <= 1'b1;
					fs_cnt_reg[i] <= fs_cnt_reg[i] + 3'h1;
				end
			end
		end
	end
end

// =============================================================
// Control word fields
// Unused bits of both words are stored but drive nothing
wire fld_hp   = pwr_a_reg[`CPAC_B_HP];
wire fld_ddm  = pwr_a_reg[`CPAC_B_DDM];
wire fld_aam  = pwr_a_reg[`CPAC_B_AAM];
wire fld_ana  = pwr_a_reg[`CPAC_B_ANA];
wire fld_pdc  = pwr_b_reg[`CPAC_B_PDC];
wire fld_clko = pwr_b_reg[`CPAC_B_CLKO];
wire fld_bt1  = pwr_b_reg[`CPAC_B_BT1];
wire fld_bt2  = pwr_b_reg[`CPAC_B_BT2];
wire fld_bt3  = pwr_b_reg[`CPAC_B_BT3];
wire fld_cv1  = pwr_b_reg[`CPAC_B_CV1];
wire fld_cv2  = pwr_b_reg[`CPAC_B_CV2];
wire fld_cv3  = pwr_b_reg[`CPAC_B_CV3];
wire fld_c1   = pwr_b_reg[`CPAC_B_C1];
wire fld_c2   = pwr_b_reg[`CPAC_B_C2];
wire fld_c3   = pwr_b_reg[`CPAC_B_C3];

// =============================================================
// Next output values; the synchronised pin overrides every enable
wire       mclk_next    = ~hw_pd & fld_clko;
wire       bt1_next     = ~hw_pd & fld_bt1;
wire       bt2_next     = ~hw_pd & fld_bt2;
wire       bt3_next     = ~hw_pd & fld_bt3;
wire       cv1_next     = ~hw_pd & fld_cv1;
wire       cv2_next     = ~hw_pd & fld_cv2;
wire       cv3_next     = ~hw_pd & fld_cv3;
wire       cg1_next     = ~hw_pd & fld_c1;
wire       cg2_next     = ~hw_pd & fld_c2;
wire       cg3_next     = ~hw_pd & fld_c3;
wire       hp_next      = ~hw_pd & fld_hp;
wire       ddm_next     = ~hw_pd & fld_ddm;
wire       aam_next     = ~hw_pd & fld_aam;
wire       adl_pwr_next = ~hw_pd & ch_pwr[0];
wire       adr_pwr_next = ~hw_pd & ch_pwr[1];
wire       da1_pwr_next = ~hw_pd & ch_pwr[2];
wire       da2_pwr_next = ~hw_pd & ch_pwr[3];
wire       ana_pwr_next = ~hw_pd & chan_on(fld_ana, fld_pdc);
// Conversion waits for calibration so host data is never uncalibrated
wire [3:0] run_next     = run_reg & {4{~running_cal & ~hw_pd}};
wire       busy_next    = running_cal & ~hw_pd;
wire       valid_next   = cal_ok_reg & ~hw_pd;

// =============================================================
// Clock outputs
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		master_clk_out_en <= 1'b0;
		bitclk_out1_en    <= 1'b0;
		bitclk_out2_en    <= 1'b0;
		bitclk_out3_en    <= 1'b0;
		convclk_out1_en   <= 1'b0;
		convclk_out2_en   <= 1'b0;
		convclk_out3_en   <= 1'b0;
		clkgen_one_en     <= 1'b0;
		clkgen_two_en     <= 1'b0;
		clkgen_three_en   <= 1'b0;
	end else begin
		master_clk_out_en <= mclk_next;
		bitclk_out1_en    <= bt1_next;
		bitclk_out2_en    <= bt2_next;
		bitclk_out3_en    <= bt3_next;
		convclk_out1_en   <= cv1_next;
		convclk_out2_en   <= cv2_next;
		convclk_out3_en   <= cv3_next;
		clkgen_one_en     <= cg1_next;
		clkgen_two_en     <= cg2_next;
		clkgen_three_en   <= cg3_next;
	end
end

// =============================================================
// Analog and channel power outputs
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		headphone_drv_en  <= 1'b0;
		dac_to_dac_mix_en <= 1'b0;
		analog_mix_en     <= 1'b0;
		adc_left_pwr      <= 1'b0;
		adc_right_pwr     <= 1'b0;
		dac_one_pwr       <= 1'b0;
		dac_two_pwr       <= 1'b0;
		analog_pwr        <= 1'b0;
	end else begin
		headphone_drv_en  <= hp_next;
		dac_to_dac_mix_en <= ddm_next;
		analog_mix_en     <= aam_next;
		adc_left_pwr      <= adl_pwr_next;
		adc_right_pwr     <= adr_pwr_next;
		dac_one_pwr       <= da1_pwr_next;
		dac_two_pwr       <= da2_pwr_next;
		analog_pwr        <= ana_pwr_next;
	end
end

// =============================================================
// Conversion and status outputs
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		adc_left_run      <= 1'b0;
		adc_right_run     <= 1'b0;
		dac_one_run       <= 1'b0;
		dac_two_run       <= 1'b0;
		cal_busy          <= 1'b0;
		cal_valid         <= 1'b0;
		hw_pd_active      <= 1'b0;
	end else begin
		adc_left_run      <= run_next[0];
		adc_right_run     <= run_next[1];
		dac_one_run       <= run_next[2];
		dac_two_run       <= run_next[3];
		cal_busy          <= busy_next;
		cal_valid         <= valid_next;
		hw_pd_active      <= hw_pd;
	end
end

endmodule // cpac_ctrl
`default_nettype wire

// >>> src/cpac_defines.vh
// Summary of operation
// - The power-down pin forces hardware power-down regardless of software enables.
// - Software enables arrive as control words for addresses 27 and 28.
// - Every resource has its own enable; any subset may be shut down.
// - Calibration starts by itself after power-up, without host action.
// - Leaving software power-down with autocal_on_wake clear reuses stored calibration immediately.
// - Calibration stays valid until reset or power-down pin is asserted.
// - With autocal_on_wake set, leaving software power-down runs a calibration.
// - Hardware reset or power-down discards calibration; a fresh one follows.
// - A calibration cycle lasts about 4 ms.
// - master_clk_out_en low stops the master clock output.
// - Each bit clock and conversion clock output has its own enable.
// - Each clock generator powers down by its own enable.
// - Headphone driver and both mixers power down by their enables.
// - Left and right ADC channels power down separately.
// - Each DAC enable powers down its whole stereo channel.
// - analog_section_en low powers down analog parts of ADC and DACs.
// - converter_pd high powers down all four conversion channels.
// - A newly enabled channel starts at first conversion clock edge after sixth frame sync, or at the end of calibration if that comes later.
`ifndef CPAC_DEFINES_VH
`define CPAC_DEFINES_VH

`define CPAC_ADDR_PWR_A   5'h1b
`define CPAC_ADDR_PWR_B   5'h1c
// Address 27 field positions
`define CPAC_B_HP         15
`define CPAC_B_DDM        14
`define CPAC_B_AAM        13
`define CPAC_B_ADL        12
`define CPAC_B_ADR        11
`define CPAC_B_DA1        10
`define CPAC_B_DA2        9
`define CPAC_B_ANA        8
// Address 28 field positions
`define CPAC_B_PDC        15
`define CPAC_B_ACW        14
`define CPAC_B_CLKO       13
`define CPAC_B_BT3        12
`define CPAC_B_BT2        11
`define CPAC_B_BT1        10
`define CPAC_B_CV3        9
`define CPAC_B_CV2        8
`define CPAC_B_CV1        7
`define CPAC_B_C3         6
`define CPAC_B_C2         5
`define CPAC_B_C1         4
// Reset values: everything off, converters powered down
`define CPAC_RST_A        16'h0000
`define CPAC_RST_B        16'h8000
// Calibration time and frame-sync count before a channel starts
`define CPAC_CAL_US       4000
`define CPAC_CLK_MHZ      200
`define CPAC_FS_WAIT      3'h6

`endif

// >>> bench/cpac_checker.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Power and calibration checks
module cpac_checker (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        wr_stb,
	input wire logic [4:0]  wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic        master_clk_out_en,
	input wire logic        headphone_drv_en,
	input wire logic        dac_one_pwr,
	input wire logic        dac_one_run,
	input wire logic        cal_busy,
	input wire logic        cal_valid,
	input wire logic        hw_pd_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_pd;
		hw_pd_active |-> !master_clk_out_en && !dac_one_run && !cal_valid;
	endproperty
	a_pd: assert property (p_pd) else $error("pin power-down left outputs on");
	property p_clko;
		wr_stb && wr_addr == 5'h1c && !hw_pd_active
		|-> ##2 master_clk_out_en == $past(wr_data[13], 2);
	endproperty
	a_clko: assert property (p_clko) else $error("clock out enable wrong");
	property p_hp;
		wr_stb && wr_addr == 5'h1b && !hw_pd_active
		|-> ##2 headphone_drv_en == $past(wr_data[15], 2);
	endproperty
	a_hp: assert property (p_hp) else $error("headphone enable wrong");
	property p_run;
		$rose(dac_one_run) |-> dac_one_pwr && cal_valid;
	endproperty
	a_run: assert property (p_run) else $error("channel ran unpowered");
	property p_cal_len;
		$rose(cal_busy) |-> cal_busy [*8];
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration too short");
	property p_cal_end;
		$rose(cal_busy) |-> ##[16:40] !cal_busy;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration too long");
	property p_valid;
		$fell(cal_busy) && !hw_pd_active |-> cal_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("no valid after calibration");
	property p_recal;
		$fell(hw_pd_active) |-> ##[0:6] cal_busy;
	endproperty
	a_recal: assert property (p_recal) else $error("no calibration after pin");
endmodule // cpac_checker

bind cpac_ctrl cpac_checker i_cpac_checker (
	.clk_sys(clk_sys), .rst_n(rst_n), .wr_stb(wr_stb), .wr_addr(wr_addr),
	.wr_data(wr_data), .master_clk_out_en(master_clk_out_en),
	.headphone_drv_en(headphone_drv_en), .dac_one_pwr(dac_one_pwr),
	.dac_one_run(dac_one_run), .cal_busy(cal_busy), .cal_valid(cal_valid),
	.hw_pd_active(hw_pd_active));
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Bench
module tb;
	logic        clk_sys = 0, rst_n = 0, hw_powerdown_pin_n = 1, wr_stb = 0;
	logic        serial_frame_sync = 0, conversion_clock_pin = 0;
	logic [4:0]  wr_addr = 0;
	logic [15:0] wr_data = 0;
	wire  [9:0]  o28;
	wire  [7:0]  o27;
	wire  [3:0]  runs;
	wire         busy, valid, hpd;
	int          error_cnt = 0, total_checks = 0, b;

	always #2.5 clk_sys = ~clk_sys;

	// Short calibration keeps the run brief
	cpac_ctrl #(.CAL_CYCLES(20)) i_cpac_ctrl (.clk_sys, .rst_n, .hw_powerdown_pin_n,
		.wr_stb, .wr_addr, .wr_data, .serial_frame_sync, .conversion_clock_pin,
		.master_clk_out_en(o28[9]), .bitclk_out3_en(o28[8]), .bitclk_out2_en(o28[7]),
		.bitclk_out1_en(o28[6]), .convclk_out3_en(o28[5]), .convclk_out2_en(o28[4]),
		.convclk_out1_en(o28[3]), .clkgen_three_en(o28[2]), .clkgen_two_en(o28[1]),
		.clkgen_one_en(o28[0]), .headphone_drv_en(o27[7]), .dac_to_dac_mix_en(o27[6]),
		.analog_mix_en(o27[5]), .adc_left_pwr(o27[4]), .adc_right_pwr(o27[3]),
		.dac_one_pwr(o27[2]), .dac_two_pwr(o27[1]), .analog_pwr(o27[0]),
		.adc_left_run(runs[0]), .adc_right_run(runs[1]), .dac_one_run(runs[2]),
		.dac_two_run(runs[3]),
		.cal_busy(busy), .cal_valid(valid), .hw_pd_active(hpd));

	// =====
	// Tasks
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask

	// Outputs follow one edge after the write edge
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1 wr_stb = 1;
		wr_addr = a;
		wr_data = d;
		@(posedge clk_sys);
		#1 wr_stb = 0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// Pins are synchronised inside, so each pulse lasts three cycles and each gap four
	task edges(input bit w, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk_sys);
			#1 conversion_clock_pin = w;
			serial_frame_sync = !w;
			repeat (3) @(posedge clk_sys);
			#1 conversion_clock_pin = 0;
			serial_frame_sync = 0;
			repeat (3) @(posedge clk_sys);
		end
		#1;
	endtask

	task cal_run;
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			#1 n++;
		end
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1 n++;
		end
		#1;
		chk("cal_len", n >= 16 && n <= 24, 1);
		chk("valid", valid, 1);
	endtask

	// =====
	// Tests
	initial begin
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1;
		cal_run();
		for (b = 4; b < 14; b++) begin
			wr(5'h1c, 16'h1 << b);
			chk("o28", o28, 16'h1 << (b - 4));
			chk("busy", busy, 0);
		end
		for (b = 8; b < 16; b++) begin
			wr(5'h1b, 16'h1 << b);
			chk("o27", o27, 16'h1 << (b - 8));
			chk("valid", valid, 1);
		end
		wr(5'h1a, 16'hffff);
		chk("other", o27, 8'h80);
		wr(5'h1b, 16'hff00);
		wr(5'h1c, 16'h8000);
		chk("cpd", o27, 8'he0);
		wr(5'h1c, 16'h0000);
		wr(5'h1b, 16'h1e00);
		chk("wake", busy, 0);
		edges(0, 5);
		edges(1, 1);
		chk("run5", runs, 0);
		edges(0, 1);
		chk("run6", runs, 0);
		edges(1, 1);
		chk("run", runs, 4'hf);
		wr(5'h1b, 16'h1a00);
		chk("dac_one_off", runs, 4'hb);
		wr(5'h1b, 16'h1200);
		chk("adc_right_off", runs, 4'h9);
		wr(5'h1b, 16'h0000);
		wr(5'h1c, 16'h4000);
		wr(5'h1b, 16'h0400);
		cal_run();
		wr(5'h1c, 16'h2000);
		hw_powerdown_pin_n = 0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("hpd", hpd, 1);
		chk("pd_valid", valid, 0);
		wr(5'h1c, 16'h2000);
		chk("pd_o28", o28, 0);
		hw_powerdown_pin_n = 1;
		cal_run();
		chk("words", o28, 0);
		give_verdict();
	end

	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end
endmodule // tb
`default_nettype wire
